// ---- hw/lam_pkg.sv ----
// constants, offsets, limits and types of the local adjust menu
// assumes a 200 MHz ref_clk and an APB master with 32-bit data
package lam_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int REPEAT_MS = 100;
  localparam int REPEAT_CYC = CLK_HZ / 1000 * REPEAT_MS;
  localparam int VAL_W = 15;
  // targets and gain held in tenths, times in whole units
  localparam logic [14:0] TARGET_MIN = 15'h0000;
  localparam logic [14:0] TARGET_MAX = 15'h03e8;
  localparam logic [14:0] GAIN_MAX = 15'h03e8;
  localparam logic [14:0] ITIME_MAX = 15'h03e7;
  localparam logic [14:0] DTIME_MAX = 15'h03e7;
  localparam logic [14:0] RTIME_MAX = 15'h4e1f;
  localparam logic [14:0] VAL_ZERO = 15'h0000;
  localparam logic [14:0] RST_TARGET = 15'h0000;
  localparam logic [14:0] RST_OUTPUT = 15'h0000;
  localparam logic [14:0] RST_GAIN = 15'h000a;
  localparam logic [14:0] RST_ITIME = 15'h000a;
  localparam logic [14:0] RST_DTIME = 15'h0000;
  localparam logic [14:0] RST_OUT_LO = 15'h0000;
  localparam logic [14:0] RST_OUT_HI = 15'h03e8;
  localparam logic [3:0] RST_UNIT = 4'h0;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_OUTPUT = 8'h08;
  localparam logic [7:0] OFS_GAIN = 8'h0c;
  localparam logic [7:0] OFS_ITIME = 8'h10;
  localparam logic [7:0] OFS_DTIME = 8'h14;
  localparam logic [7:0] OFS_RTIME = 8'h18;
  localparam logic [7:0] OFS_LIMITS = 8'h1c;
  localparam logic [7:0] OFS_EVENTS = 8'h20;
  // field positions
  localparam int LIM_HI_POS = 16;
  localparam int EV_ACK_BIT = 0;
  localparam int EV_OPSAVE_BIT = 1;
  localparam int EV_TNSAVE_BIT = 2;
  // menu item indices
  localparam logic [3:0] MN_LOOP_HANDLING_BRANCH = 4'h0;
  localparam logic [3:0] MN_BATCH = 4'h1;
  localparam logic [3:0] MN_TUNE = 4'h2;
  localparam logic [3:0] MN_SETUP_BRANCH = 4'h3;
  localparam logic [3:0] MN_ESC = 4'h4;
  localparam logic [3:0] OP_AM = 4'h0;
  localparam logic [3:0] OP_SP_UP = 4'h1;
  localparam logic [3:0] OP_SP_DN = 4'h2;
  localparam logic [3:0] OP_OUT_UP = 4'h3;
  localparam logic [3:0] OP_OUT_DN = 4'h4;
  localparam logic [3:0] OP_ACK = 4'h5;
  localparam logic [3:0] OP_SAVE = 4'h6;
  localparam logic [3:0] OP_ESC = 4'h7;
  localparam logic [3:0] BT_ONOFF = 4'h0;
  localparam logic [3:0] BT_RUN = 4'h1;
  localparam logic [3:0] BT_RESET = 4'h2;
  localparam logic [3:0] BT_T_UP = 4'h3;
  localparam logic [3:0] BT_T_DN = 4'h4;
  localparam logic [3:0] BT_ESC = 4'h5;
  localparam logic [3:0] TN_G_UP = 4'h0;
  localparam logic [3:0] TN_G_DN = 4'h1;
  localparam logic [3:0] TN_I_UP = 4'h2;
  localparam logic [3:0] TN_I_DN = 4'h3;
  localparam logic [3:0] TN_D_UP = 4'h4;
  localparam logic [3:0] TN_D_DN = 4'h5;
  localparam logic [3:0] TN_DIR = 4'h6;
  localparam logic [3:0] TN_SAVE = 4'h7;
  localparam logic [3:0] TN_ESC = 4'h8;
  localparam logic [3:0] CF_UNIT = 4'h0;
  localparam logic [3:0] CF_ESC = 4'h1;
  // unit list: C F R K mV ohm special none, then escape
  localparam logic [3:0] UL_ESC = 4'h8;
  localparam logic [7:0] CHR_A = 8'h41;
  localparam logic [7:0] CHR_M = 8'h4d;
  localparam logic [7:0] CHR_D = 8'h44;
  localparam logic [7:0] CHR_R = 8'h52;
  typedef enum logic [2:0] {
    ST_MON, ST_MAIN, ST_LOOP_HANDLING_BRANCH, ST_BATCH, ST_TUNE, ST_SETUP_BRANCH, ST_ULIST
  } lam_state_t;
endpackage : lam_pkg

// ---- hw/lam_debounce.sv ----
// two-flop synchroniser and debounce filter for one switch pin
// assumes raw input is asynchronous to ref_clk
`timescale 1ns/1ps
module lam_debounce #(
  parameter int CYC = 4_000_000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic raw_in,
  output logic stable
);
  localparam int CW = $clog2(CYC + 1);
  logic sync1_r;
  logic sync2_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // level must hold CYC cycles before it is accepted
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      stable <= 1'b0;
    end else if (sync2_r == stable) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(CYC - 1)) begin
      cnt_r <= '0;
      stable <= sync2_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : lam_debounce

// ---- hw/lam_menu.sv ----
// two-switch local adjust menu with APB register access
// assumes asynchronous switch and mode pins, APB master on ref_clk
//
// Operation
// - advance from monitoring enters main menu
// - transmitter mode enters configuration at unit
// - main menu order, activate enters branch
// - operation starts at auto/manual, toggles
// - held target ramp stops at limits
// - held output ramp stops at configured limits
// - acknowledge clears all alarms together
// - operation save stores target and output
// - operation item order, escape wraps/returns
// - batch starts at generator on/off toggle
// - pause/run item toggles generator state
// - reset item clears generator time
// - held time ramp stops at limits
// - batch item order, escape wraps/returns
// - tuning starts at gain, ramps limited
// - integral time ramps within limits
// - derivative time ramps within limits
// - action toggles, D or R shown
// - tuning save stores three constants
// - configuration unit list, step and select
// - escape in unit list keeps unit
// - advance moves, activate executes selection
`timescale 1ns/1ps
module lam_menu import lam_pkg::*; #(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int REP_CYC = REPEAT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic adv_sw_in,
  input wire logic act_sw_in,
  input wire logic xmtr_mode_in,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [14:0] target_value,
  output logic [14:0] controller_output,
  output logic [14:0] proportional_gain,
  output logic [14:0] integral_time,
  output logic [14:0] derivative_time,
  output logic [14:0] ramp_time,
  output logic auto_mode,
  output logic ramp_on,
  output logic ramp_run,
  output logic control_direction,
  output logic [7:0] mode_char,
  output logic [7:0] dir_char,
  output logic [3:0] eng_unit,
  output logic alarm_ack,
  output logic op_save,
  output logic tune_save
);
  localparam int RW = $clog2(REP_CYC + 1);

  function automatic logic [14:0] lam_step(input logic [14:0] v,
      input logic up, input logic [14:0] lo, input logic [14:0] hi);
    if (up) lam_step = (v >= hi) ? hi : v + 15'h0001;
    else lam_step = (v <= lo) ? lo : v - 15'h0001;
  endfunction : lam_step

  function automatic logic [14:0] lam_clamp(input logic [31:0] d,
      input logic [14:0] lo, input logic [14:0] hi);
    if (d > {17'h00000, hi}) lam_clamp = hi;
    else if (d < {17'h00000, lo}) lam_clamp = lo;
    else lam_clamp = d[14:0];
  endfunction : lam_clamp

  function automatic logic [3:0] lam_next(input logic [3:0] i,
      input logic [3:0] last);
    lam_next = (i == last) ? 4'h0 : i + 4'h1;
  endfunction : lam_next

  logic adv_lvl;
  logic act_lvl;
  logic adv_q_r;
  logic act_q_r;
  logic mode_s1_r;
  logic xmtr_r;
  logic [RW-1:0] rep_cnt_r;
  lam_state_t state_r;
  logic [3:0] item_r;
  logic [14:0] out_lo_r;
  logic [14:0] out_hi_r;
  logic [2:0] events_r;

  lam_debounce #(.CYC(DEB_CYC)) u_adv_db (
    .ref_clk(ref_clk), .rst(rst), .raw_in(adv_sw_in), .stable(adv_lvl)
  );
  lam_debounce #(.CYC(DEB_CYC)) u_act_db (
    .ref_clk(ref_clk), .rst(rst), .raw_in(act_sw_in), .stable(act_lvl)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      adv_q_r <= 1'b0;
      act_q_r <= 1'b0;
      mode_s1_r <= 1'b0;
      xmtr_r <= 1'b0;
    end else begin
      adv_q_r <= adv_lvl;
      act_q_r <= act_lvl;
      mode_s1_r <= xmtr_mode_in;
      xmtr_r <= mode_s1_r;
    end
  end

  // one event per press; advance wins a tie
  logic adv_ev;
  logic act_ev;
  assign adv_ev = adv_lvl & ~adv_q_r;
  assign act_ev = act_lvl & ~act_q_r & ~adv_ev;

  // held activate repeats at a fixed rate
  logic rep_tick;
  assign rep_tick = act_lvl & (rep_cnt_r == RW'(REP_CYC - 1));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) rep_cnt_r <= '0;
    else if (!act_lvl || rep_tick) rep_cnt_r <= '0;
    else rep_cnt_r <= rep_cnt_r + 1'b1;
  end
  logic ramp_ev;
  assign ramp_ev = act_ev | (rep_tick & ~adv_ev);

  function automatic logic at(input lam_state_t s, input logic [3:0] i,
      input lam_state_t cs, input logic [3:0] ci);
    at = (cs == s) && (ci == i);
  endfunction : at

  // menu state machine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_MON;
      item_r <= 4'h0;
    end else begin
      case (state_r)
        ST_MON: if (adv_ev) begin
          state_r <= xmtr_r ? ST_SETUP_BRANCH : ST_MAIN;
          item_r <= 4'h0;
        end
        ST_MAIN: if (adv_ev) begin
          item_r <= lam_next(item_r, MN_ESC);
        end else if (act_ev) begin
          item_r <= 4'h0;
          case (item_r)
            MN_LOOP_HANDLING_BRANCH: state_r <= ST_LOOP_HANDLING_BRANCH;
            MN_BATCH: state_r <= ST_BATCH;
            MN_TUNE: state_r <= ST_TUNE;
            MN_SETUP_BRANCH: state_r <= ST_SETUP_BRANCH;
            default: state_r <= ST_MON;
          endcase
        end
        ST_LOOP_HANDLING_BRANCH: if (adv_ev) begin
          item_r <= lam_next(item_r, OP_ESC);
        end else if (act_ev && item_r == OP_ESC) begin
          state_r <= ST_MAIN;
          item_r <= 4'h0;
        end
        ST_BATCH: if (adv_ev) begin
          item_r <= lam_next(item_r, BT_ESC);
        end else if (act_ev && item_r == BT_ESC) begin
          state_r <= ST_MAIN;
          item_r <= 4'h0;
        end
        ST_TUNE: if (adv_ev) begin
          item_r <= lam_next(item_r, TN_ESC);
        end else if (act_ev && item_r == TN_ESC) begin
          state_r <= ST_MAIN;
          item_r <= 4'h0;
        end
        ST_SETUP_BRANCH: if (adv_ev) begin
          item_r <= lam_next(item_r, CF_ESC);
        end else if (act_ev) begin
          if (item_r == CF_UNIT) state_r <= ST_ULIST;
          else state_r <= xmtr_r ? ST_MON : ST_MAIN;
          item_r <= 4'h0;
        end
        ST_ULIST: if (adv_ev) begin
          item_r <= lam_next(item_r, UL_ESC);
        end else if (act_ev) begin
          state_r <= ST_SETUP_BRANCH;
          item_r <= CF_UNIT;
        end
        default: begin
          state_r <= ST_MON;
          item_r <= 4'h0;
        end
      endcase
    end
  end

  // unit selection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) eng_unit <= RST_UNIT;
    else if (state_r == ST_ULIST && act_ev && item_r != UL_ESC)
      eng_unit <= item_r;
  end

  // apb slave: one wait cycle, answer registered
  logic apb_acc;
  logic wr_en;
  logic mapped;
  assign apb_acc = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_EVENTS);

  function automatic logic wr_at(input logic en, input logic [7:0] a,
      input logic [7:0] o);
    wr_at = en && (a == o);
  endfunction : wr_at

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~mapped;
      if (apb_acc) begin
        case (paddr)
          OFS_STATUS: prdata <= {15'h0000, xmtr_r, control_direction,
            ramp_run, ramp_on, auto_mode, eng_unit, item_r, 1'b0,
            state_r};
          OFS_TARGET: prdata <= {17'h00000, target_value};
          OFS_OUTPUT: prdata <= {17'h00000, controller_output};
          OFS_GAIN: prdata <= {17'h00000, proportional_gain};
          OFS_ITIME: prdata <= {17'h00000, integral_time};
          OFS_DTIME: prdata <= {17'h00000, derivative_time};
          OFS_RTIME: prdata <= {17'h00000, ramp_time};
          OFS_LIMITS: prdata <= {1'b0, out_hi_r, 1'b0, out_lo_r};
          OFS_EVENTS: prdata <= {29'h00000000, events_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_lo_r <= RST_OUT_LO;
      out_hi_r <= RST_OUT_HI;
    end else if (wr_at(wr_en, paddr, OFS_LIMITS)) begin
      out_lo_r <= lam_clamp({17'h00000, pwdata[14:0]}, VAL_ZERO,
        TARGET_MAX);
      out_hi_r <= lam_clamp({17'h00000, pwdata[LIM_HI_POS +: 15]},
        VAL_ZERO, TARGET_MAX);
    end
  end

  // switch steps take priority over software writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) target_value <= RST_TARGET;
    else if (ramp_ev && (at(ST_LOOP_HANDLING_BRANCH, OP_SP_UP, state_r, item_r) ||
        at(ST_LOOP_HANDLING_BRANCH, OP_SP_DN, state_r, item_r)))
      target_value <= lam_step(target_value, item_r == OP_SP_UP,
        TARGET_MIN, TARGET_MAX);
    else if (wr_at(wr_en, paddr, OFS_TARGET))
      target_value <= lam_clamp(pwdata, TARGET_MIN, TARGET_MAX);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) controller_output <= RST_OUTPUT;
    else if (ramp_ev && (at(ST_LOOP_HANDLING_BRANCH, OP_OUT_UP, state_r, item_r) ||
        at(ST_LOOP_HANDLING_BRANCH, OP_OUT_DN, state_r, item_r)))
      controller_output <= lam_step(controller_output,
        item_r == OP_OUT_UP, out_lo_r, out_hi_r);
    else if (wr_at(wr_en, paddr, OFS_OUTPUT))
      controller_output <= lam_clamp(pwdata, out_lo_r, out_hi_r);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) proportional_gain <= RST_GAIN;
    else if (ramp_ev && (at(ST_TUNE, TN_G_UP, state_r, item_r) ||
        at(ST_TUNE, TN_G_DN, state_r, item_r)))
      proportional_gain <= lam_step(proportional_gain,
        item_r == TN_G_UP, VAL_ZERO, GAIN_MAX);
    else if (wr_at(wr_en, paddr, OFS_GAIN))
      proportional_gain <= lam_clamp(pwdata, VAL_ZERO, GAIN_MAX);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) integral_time <= RST_ITIME;
    else if (ramp_ev && (at(ST_TUNE, TN_I_UP, state_r, item_r) ||
        at(ST_TUNE, TN_I_DN, state_r, item_r)))
      integral_time <= lam_step(integral_time, item_r == TN_I_UP,
        VAL_ZERO, ITIME_MAX);
    else if (wr_at(wr_en, paddr, OFS_ITIME))
      integral_time <= lam_clamp(pwdata, VAL_ZERO, ITIME_MAX);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) derivative_time <= RST_DTIME;
    else if (ramp_ev && (at(ST_TUNE, TN_D_UP, state_r, item_r) ||
        at(ST_TUNE, TN_D_DN, state_r, item_r)))
      derivative_time <= lam_step(derivative_time, item_r == TN_D_UP,
        VAL_ZERO, DTIME_MAX);
    else if (wr_at(wr_en, paddr, OFS_DTIME))
      derivative_time <= lam_clamp(pwdata, VAL_ZERO, DTIME_MAX);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) ramp_time <= VAL_ZERO;
    else if (act_ev && at(ST_BATCH, BT_RESET, state_r, item_r))
      ramp_time <= VAL_ZERO;
    else if (ramp_ev && (at(ST_BATCH, BT_T_UP, state_r, item_r) ||
        at(ST_BATCH, BT_T_DN, state_r, item_r)))
      ramp_time <= lam_step(ramp_time, item_r == BT_T_UP, VAL_ZERO,
        RTIME_MAX);
    else if (wr_at(wr_en, paddr, OFS_RTIME))
      ramp_time <= lam_clamp(pwdata, VAL_ZERO, RTIME_MAX);
  end

  // toggles and their display characters
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      auto_mode <= 1'b1;
      mode_char <= CHR_A;
    end else if (act_ev && at(ST_LOOP_HANDLING_BRANCH, OP_AM, state_r, item_r)) begin
      auto_mode <= ~auto_mode;
      mode_char <= auto_mode ? CHR_M : CHR_A;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control_direction <= 1'b0;
      dir_char <= CHR_D;
    end else if (act_ev && at(ST_TUNE, TN_DIR, state_r, item_r)) begin
      control_direction <= ~control_direction;
      dir_char <= control_direction ? CHR_D : CHR_R;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ramp_on <= 1'b0;
      ramp_run <= 1'b0;
    end else begin
      if (act_ev && at(ST_BATCH, BT_ONOFF, state_r, item_r))
        ramp_on <= ~ramp_on;
      if (act_ev && at(ST_BATCH, BT_RUN, state_r, item_r))
        ramp_run <= ~ramp_run;
    end
  end

  // one-cycle strobes to alarm logic and nonvolatile store
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarm_ack <= 1'b0;
      op_save <= 1'b0;
      tune_save <= 1'b0;
    end else begin
      alarm_ack <= act_ev && at(ST_LOOP_HANDLING_BRANCH, OP_ACK, state_r, item_r);
      op_save <= act_ev && at(ST_LOOP_HANDLING_BRANCH, OP_SAVE, state_r, item_r);
      tune_save <= act_ev && at(ST_TUNE, TN_SAVE, state_r, item_r);
    end
  end

  // sticky event bits, write one to clear, set beats clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) events_r <= 3'h0;
    else events_r <= (events_r & ~(wr_at(wr_en, paddr, OFS_EVENTS) ?
      pwdata[2:0] : 3'h0)) | {tune_save, op_save, alarm_ack};
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_enter_main: assert property (state_r == ST_MON && adv_ev && !xmtr_r
    |=> state_r == ST_MAIN && item_r == MN_LOOP_HANDLING_BRANCH)
    else $error("advance in monitor did not open main menu");
  a_xmtr_entry: assert property (state_r == ST_MON && adv_ev && xmtr_r
    |=> state_r == ST_SETUP_BRANCH && item_r == CF_UNIT)
    else $error("transmitter entry not at unit item");
  a_main_wrap: assert property (state_r == ST_MAIN && adv_ev &&
    item_r == MN_ESC |=> item_r == MN_LOOP_HANDLING_BRANCH)
    else $error("main menu did not wrap");
  a_am_toggle: assert property (act_ev && at(ST_LOOP_HANDLING_BRANCH, OP_AM, state_r,
    item_r) |=> auto_mode != $past(auto_mode) &&
    mode_char == (auto_mode ? CHR_A : CHR_M))
    else $error("auto/manual toggle wrong");
  a_target_lim: assert property (target_value <= TARGET_MAX)
    else $error("target above limit");
  a_loop_handling_branch_esc: assert property (act_ev && at(ST_LOOP_HANDLING_BRANCH, OP_ESC, state_r,
    item_r) |=> state_r == ST_MAIN)
    else $error("operation escape did not return");
  a_time_reset: assert property (act_ev && at(ST_BATCH, BT_RESET,
    state_r, item_r) |=> ramp_time == VAL_ZERO)
    else $error("generator time not cleared");
  a_time_lim: assert property (ramp_time <= RTIME_MAX)
    else $error("generator time above limit");
  a_save_pulse: assert property (act_ev && at(ST_TUNE, TN_SAVE, state_r,
    item_r) |=> tune_save ##1 !tune_save)
    else $error("tuning save strobe not one cycle");
  a_unit_keep: assert property (act_ev && at(ST_ULIST, UL_ESC, state_r,
    item_r) |=> $stable(eng_unit) && state_r == ST_SETUP_BRANCH)
    else $error("unit escape changed unit");
  a_one_update: assert property ($changed(item_r) |->
    $past(adv_ev) || $past(act_ev))
    else $error("menu moved without an event");

  c_enter_loop_handling_branch: cover property (state_r == ST_MAIN ##1 state_r == ST_LOOP_HANDLING_BRANCH);
  c_held_ramp: cover property (rep_tick && state_r == ST_LOOP_HANDLING_BRANCH);
  c_unit_pick: cover property (act_ev && state_r == ST_ULIST);
endmodule : lam_menu

// ---- sim/lam_operator.sv ----
// operator model: magnetic tool on the advance and activate switches
// assumes the bench calls press; pins read low while the tool is away
`timescale 1ns/1ps
module lam_operator (
  input wire logic ref_clk,
  output logic adv_sw,
  output logic act_sw
);
  initial begin
    adv_sw = 1'b0;
    act_sw = 1'b0;
  end
  // hold n cycles, then stay away long enough to debounce
  task automatic press(input logic act, input int n);
    @(posedge ref_clk);
    if (act) act_sw <= 1'b1;
    else adv_sw <= 1'b1;
    repeat (n) @(posedge ref_clk);
    act_sw <= 1'b0;
    adv_sw <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask : press
endmodule : lam_operator

// ---- sim/tb_top.sv ----
// bench for the local adjust menu: apb tasks, operator model
// assumes small debounce and repeat counts of 4 and 16 cycles
`timescale 1ns/1ps
module tb_top import lam_pkg::*; ();
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic adv_sw_in, act_sw_in;
  logic xmtr_mode_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic [14:0] target_value, controller_output, ramp_time;
  logic auto_mode, ramp_on, ramp_run, control_direction;
  logic [7:0] mode_char, dir_char;
  logic [3:0] eng_unit;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  lam_operator op_i (.ref_clk, .adv_sw(adv_sw_in), .act_sw(act_sw_in));
  lam_menu #(.DEB_CYC(4), .REP_CYC(16)) lam_menu_i (
    .ref_clk, .rst, .adv_sw_in, .act_sw_in, .xmtr_mode_in, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .target_value,
    .controller_output, .proportional_gain(), .integral_time(),
    .derivative_time(), .ramp_time, .auto_mode, .ramp_on, .ramp_run,
    .control_direction, .mode_char, .dir_char, .eng_unit, .alarm_ack(),
    .op_save(), .tune_save());
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the bench cycle ceiling ends a wait for pready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic adv(input int n);
    repeat (n) op_i.press(1'b0, 12);
  endtask : adv
  task automatic tap();
    op_i.press(1'b1, 12);
  endtask : tap
  task automatic st(input logic [3:0] it, input logic [2:0] s);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({q[7:4], q[2:0]}, {it, s});
  endtask : st
  // hold activate near each limit; value must stop there, not wrap
  task automatic updown(input logic [7:0] a, input logic [14:0] lo,
                        input logic [14:0] hi);
    apb(1'b1, a, {17'h0, hi - 15'h2});
    op_i.press(1'b1, 200);
    apb(1'b0, a, 32'h0);
    chk(q, {17'h0, hi});
    adv(1);
    apb(1'b1, a, {17'h0, lo + 15'h2});
    op_i.press(1'b1, 200);
    apb(1'b0, a, 32'h0);
    chk(q, {17'h0, lo});
  endtask : updown
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    chk(mode_char, CHR_A);
    adv(1);
    st(4'h0, 3'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    tap();
    st(OP_AM, 3'h2);
    tap();
    chk({auto_mode, mode_char}, {1'b0, CHR_M});
    adv(1);
    updown(OFS_TARGET, TARGET_MIN, TARGET_MAX);
    apb(1'b1, OFS_LIMITS, 32'h000a_0005);
    adv(1);
    updown(OFS_OUTPUT, 15'h0005, 15'h000a);
    adv(1);
    tap();
    adv(1);
    tap();
    apb(1'b0, OFS_EVENTS, 32'h0);
    chk(q[1:0], 2'b11);
    adv(2);
    st(OP_AM, 3'h2);
    adv(7);
    tap();
    st(MN_LOOP_HANDLING_BRANCH, 3'h1);
    $display("operation branch done");
    adv(1);
    tap();
    st(BT_ONOFF, 3'h3);
    tap();
    chk(ramp_on, 1'b1);
    adv(1);
    tap();
    chk(ramp_run, 1'b1);
    apb(1'b1, OFS_RTIME, 32'h5);
    adv(1);
    tap();
    chk(ramp_time, VAL_ZERO);
    adv(1);
    updown(OFS_RTIME, VAL_ZERO, RTIME_MAX);
    adv(1);
    tap();
    st(MN_LOOP_HANDLING_BRANCH, 3'h1);
    adv(2);
    tap();
    st(TN_G_UP, 3'h4);
    updown(OFS_GAIN, VAL_ZERO, GAIN_MAX);
    adv(1);
    updown(OFS_ITIME, VAL_ZERO, ITIME_MAX);
    adv(1);
    updown(OFS_DTIME, VAL_ZERO, DTIME_MAX);
    adv(1);
    tap();
    chk({control_direction, dir_char}, {1'b1, CHR_R});
    adv(1);
    tap();
    apb(1'b0, OFS_EVENTS, 32'h0);
    chk(q[2], 1'b1);
    adv(1);
    tap();
    $display("batch and tuning done");
    adv(3);
    tap();
    st(CF_UNIT, 3'h5);
    tap();
    adv(2);
    tap();
    chk(eng_unit, 4'h2);
    tap();
    adv(8);
    tap();
    chk(eng_unit, 4'h2);
    adv(1);
    tap();
    adv(4);
    tap();
    op_i.press(1'b0, 2);
    st(4'h0, 3'h0);
    xmtr_mode_in <= 1'b1;
    adv(1);
    st(CF_UNIT, 3'h5);
    $display("configuration done");
    end_sim();
  end
endmodule : tb_top
